// file: design/uss_top.sv
// Serial shift unit: shift register, counter, flags and APB registers.
`timescale 1ns/1ps
`include "uss_cfg.svh"
module uss_top (
  // System clock and reset.
  input wire logic clk_sys,
  input wire logic reset,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Timer compare match pulse, same clock domain.
  input wire logic timerMatch,
  // Serial data pin (data input, or open-drain data line).
  input wire logic dataIn,
  output logic sdaOut,
  output logic sdaOeN,
  // Three-wire data output pin.
  output logic doOut,
  output logic doOeN,
  // Serial clock pin.
  input wire logic clkIn,
  output logic clkOut,
  output logic clkOeN,
  // Interrupt and wake requests toward the processor.
  output logic irqStart,
  output logic irqOverflow,
  output logic wakeReq
);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  // Synchronised pin levels and the previous clock level.
  logic [1:0] syncIn;
  logic sclLvl, sdaLvl, sclPrev, sclRise, sclFall;
  // Register state.
  uss_pkg::uss_ctrl_s ctrl; // Control register.
  uss_pkg::uss_aux_s aux; // Auxiliary register.
  logic [7:0] shiftReg; // Shift register, accessed with no buffer.
  logic [3:0] cnt; // Edge and tick counter.
  logic startFlag, ovfFlag, stopFlag;
  // Bus decode and per-register write enables.
  logic [7:0] regIdx;
  logic aligned, hitCtrl, hitStatus, hitData, hitAux, mapped;
  logic wrEn, wrCtrl, wrStatus, wrData, wrAux;
  // Clocking of the shift register and counter, and mode decode.
  logic shiftTick, cntTick, toggleStrobe;
  logic extSel, twoWire, threeWire, collision;
  // Bus condition pulses.
  logic startSeen, stopSeen;
  // Output latch and clock hold state.
  logic latchOpen, outLatch, startHold, sdaLow, sclLow;

  // Both pins cross into this domain before anything looks at them.
  uss_sync #(.WIDTH(2)) u_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .asyncIn({clkIn, dataIn}),
    .syncOut(syncIn)
  );

  assign sclLvl = syncIn[1];
  assign sdaLvl = syncIn[0];

  // The detector runs only in two-wire modes.
  uss_bus_cond u_cond (
    .clk_sys(clk_sys),
    .reset(reset),
    .enable(twoWire),
    .sdaLevel(sdaLvl),
    .sclLevel(sclLvl),
    .startSeen(startSeen),
    .stopSeen(stopSeen)
  );

  // Remember the clock level so both of its edges can be seen.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sclPrev <= 1'b0;
    end else begin
      sclPrev <= sclLvl;
    end
  end

  assign sclRise = sclLvl & ~sclPrev;
  assign sclFall = ~sclLvl & sclPrev;

  // Mode decode; inputs stay live in every mode. [R17] [R23]
  assign twoWire = ctrl.wireModeSelect[1];
  assign threeWire = (ctrl.wireModeSelect == uss_pkg::USS_WIRE_THREE);
  assign extSel = ctrl.clockSourceSelect[1];

  // Word-aligned decode; printed offsets are indexes.
  assign regIdx = paddr[9:2];
  assign aligned = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
  assign hitCtrl = aligned && (regIdx == `USS_IDX_CTRL);
  assign hitStatus = aligned && (regIdx == `USS_IDX_STATUS);
  assign hitData = aligned && (regIdx == `USS_IDX_DATA);
  assign hitAux = aligned && (regIdx == `USS_IDX_AUX);
  assign mapped = hitCtrl | hitStatus | hitData | hitAux;

  // The slave never stalls; unmapped accesses answer with an error.
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // Writes take effect in the access phase only.
  assign wrEn = psel & penable & pwrite;
  assign wrCtrl = wrEn & hitCtrl;
  assign wrStatus = wrEn & hitStatus;
  assign wrData = wrEn & hitData;
  assign wrAux = wrEn & hitAux;

  // Strobe bits act only when written as one; the toggle acts with any source.
  assign toggleStrobe = wrCtrl & pwdata[`USS_CR_TOGGLE];

  // Select the tick that clocks the shift register and counter.
  // Strobes use the value being written, so one write can pick the
  // source and fire the strobe together.
  always_comb begin
    shiftTick = 1'b0;
    cntTick = 1'b0;
    if (wrCtrl && (pwdata[3:2] == 2'h0) && pwdata[`USS_CR_STROBE]) begin
      // Software strobe source. [R12]
      shiftTick = 1'b1;
      cntTick = 1'b1;
    end else if (toggleStrobe && pwdata[3] && pwdata[`USS_CR_STROBE]) begin
      // External source clocked by the toggle strobe. [R13]
      shiftTick = 1'b1;
      cntTick = 1'b1;
    end else if (ctrl.clockSourceSelect == 2'h1) begin
      // Timer compare source. [R12]
      shiftTick = timerMatch;
      cntTick = timerMatch;
    end else if (extSel && !ctrl.clockStrobeSelect) begin
      // Pin edges: both count, one polarity shifts. [R14]
      cntTick = sclRise | sclFall;
      shiftTick = ctrl.clockSourceSelect[0] ? sclFall : sclRise;
    end
  end

  // Control register; the toggle bit is a strobe and is not stored.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ctrl <= uss_pkg::uss_ctrl_s'(`USS_CTRL_RST);
    end else if (wrCtrl) begin
      ctrl <= uss_pkg::uss_ctrl_s'({pwdata[7:1], 1'b0});
    end
  end

  // Auxiliary register; the toggle strobe flips the clock port bit.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      aux <= uss_pkg::uss_aux_s'(`USS_AUX_RST);
    end else if (wrAux) begin
      aux <= uss_pkg::uss_aux_s'({1'b0, pwdata[6:0]});
    end else if (toggleStrobe) begin
      aux.clkPort <= ~aux.clkPort;
    end
  end

  // Shift register: a write wins over a coincident shift. [R15]
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      shiftReg <= `USS_DATA_RST;
    end else if (wrData) begin
      shiftReg <= pwdata[7:0]; // [R15]
    end else if (shiftTick) begin
      shiftReg <= {shiftReg[6:0], sdaLvl}; // [R16]
    end
  end

  // Counter: software writes take priority over counting. [R11]
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cnt <= 4'(`USS_STATUS_RST);
    end else if (wrStatus) begin
      cnt <= pwdata[3:0]; // [R11]
    end else if (cntTick) begin
      cnt <= cnt + 4'h1; // [R12]
    end
  end

  // Overflow flag: set on wrap, cleared by a written one; a status write blocks the set.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ovfFlag <= 1'b0;
    end else if (cntTick && !wrStatus && cnt == `USS_CNT_MAX) begin
      ovfFlag <= 1'b1; // [R01]
    end else if (wrStatus && pwdata[`USS_ST_OVF]) begin
      ovfFlag <= 1'b0; // [R02]
    end
  end

  // Start flag: bus start in two-wire modes, else every increment.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      startFlag <= 1'b0;
    end else if (twoWire ? startSeen : cntTick) begin
      startFlag <= 1'b1; // [R04]
    end else if (wrStatus && pwdata[`USS_ST_START]) begin
      startFlag <= 1'b0; // [R05]
    end
  end

  // Stop flag: two-wire stop only; it feeds no interrupt. [R09]
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      stopFlag <= 1'b0;
    end else if (twoWire && stopSeen) begin
      stopFlag <= 1'b1; // [R09]
    end else if (wrStatus && pwdata[`USS_ST_STOP]) begin
      stopFlag <= 1'b0; // [R09]
    end
  end

  // Collision compares the MSB with the sensed line. [R10]
  assign collision = shiftReg[7] ^ sdaLvl;

  // Read data is captured in the setup cycle so it comes from a flop.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      prdata <= 32'h0;
    end else if (psel && !penable) begin
      unique case (1'b1)
        hitCtrl: prdata <= {24'h0, ctrl};
        hitStatus: prdata <= {24'h0, startFlag, ovfFlag, stopFlag,
                              collision, cnt}; // [R10] [R11]
        hitData: prdata <= {24'h0, shiftReg};
        hitAux: prdata <= {24'h0, aux};
        default: prdata <= 32'h0;
      endcase
    end
  end

  // Latch window: with a pin clock it opens on the edge opposite to
  // sampling and closes on the sampling edge, so output and input
  // change on opposite edges; with internal clocks it stays open.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      latchOpen <= 1'b1;
    end else if (!extSel) begin
      latchOpen <= 1'b1; // [R19]
    end else if (ctrl.clockSourceSelect[0] ? sclFall : sclRise) begin
      latchOpen <= 1'b0; // [R19]
    end else if (ctrl.clockSourceSelect[0] ? sclRise : sclFall) begin
      latchOpen <= 1'b1; // [R19]
    end
  end

  // The output latch follows the MSB while open. [R18]
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      outLatch <= 1'b1;
    end else if (!extSel || latchOpen) begin
      outLatch <= shiftReg[7]; // [R18] [R19]
    end
  end

  // Start hold: after a start, the next clock fall is held low until
  // the start flag is cleared. [R05]
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      startHold <= 1'b0;
    end else begin
      startHold <= twoWire & startFlag & (startHold | sclFall); // [R05]
    end
  end

  // Open-drain pulls; overflow hold only in the second two-wire mode.
  assign sdaLow = twoWire & aux.dataDirOut & (~outLatch | ~aux.dataPort);
  assign sclLow = twoWire & aux.clkDirOut & (~aux.clkPort | startHold |
    (ctrl.wireModeSelect == uss_pkg::USS_WIRE_TWO_HOLD && ovfFlag));

  // The open-drain data line only ever drives low.
  assign sdaOut = 1'b0;

  // Pin drivers, registered; enables are active low. [R20]
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sdaOeN <= 1'b1;
      doOut <= 1'b1;
      doOeN <= 1'b1;
      clkOut <= 1'b1;
      clkOeN <= 1'b1;
    end else begin
      sdaOeN <= ~sdaLow; // [R20]
      doOut <= outLatch; // [R18]
      doOeN <= ~(threeWire & aux.dataDirOut); // [R20]
      clkOut <= twoWire ? 1'b0 : aux.clkPort;
      clkOeN <= twoWire ? ~sclLow : ~(threeWire & aux.clkDirOut); // [R24]
    end
  end

  // Interrupt requests follow flag and enables, so a pending flag
  // fires as soon as its enables are set. [R21]
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      irqStart <= 1'b0;
      irqOverflow <= 1'b0;
    end else begin
      irqStart <= startFlag & ctrl.startIrqEnable &
        aux.globalIrqEnable; // [R06]
      irqOverflow <= ovfFlag & ctrl.overflowIrqEnable &
        aux.globalIrqEnable; // [R03]
    end
  end

  // Wake: start from any sleep mode, overflow from idle only.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wakeReq <= 1'b0;
    end else begin
      wakeReq <= irqStart | (irqOverflow &&
        aux.sleepMode == `USS_SLEEP_IDLE); // [R07] [R08]
    end
  end

  a_ovf_on_wrap: assert property ( // [R01]
    cntTick && !wrStatus && cnt == 4'hf |=> ovfFlag && cnt == 4'h0)
    else $error("overflow flag missed at counter wrap");
  a_ovf_sticky: assert property ( // [R02]
    ovfFlag && !(wrStatus && pwdata[6]) |=> ovfFlag)
    else $error("overflow flag cleared without a written one");
  a_ovf_irq: assert property ( // [R03]
    ovfFlag && ctrl.overflowIrqEnable && aux.globalIrqEnable
    |=> irqOverflow)
    else $error("overflow interrupt not raised");
  a_start_on_cond: assert property ( // [R04]
    twoWire && startSeen |=> startFlag)
    else $error("start flag missed on bus start");
  a_start_sticky: assert property ( // [R05]
    startFlag && !(wrStatus && pwdata[7]) |=> startFlag)
    else $error("start flag cleared without a written one");
  a_start_irq: assert property ( // [R06]
    startFlag && ctrl.startIrqEnable && aux.globalIrqEnable |=> irqStart)
    else $error("start interrupt not raised");
  a_start_wake: assert property ( // [R07]
    irqStart |=> wakeReq)
    else $error("start interrupt did not wake");
  a_ovf_wake_idle: assert property ( // [R08]
    !irqStart && irqOverflow && aux.sleepMode != 2'h1 |=> !wakeReq)
    else $error("overflow woke outside idle");
  a_coll_read: assert property ( // [R10]
    psel && !penable && hitStatus
    |=> prdata[4] == $past(collision) && prdata[3:0] == $past(cnt))
    else $error("status read wrong");
  a_write_wins: assert property ( // [R15]
    wrData |=> shiftReg == $past(pwdata[7:0]))
    else $error("data write lost to shift");
  a_shift_in: assert property ( // [R16]
    shiftTick && !wrData
    |=> shiftReg == {$past(shiftReg[6:0]), $past(sdaLvl)})
    else $error("shift wrong");
  a_do_dir: assert property ( // [R20]
    !aux.dataDirOut |=> doOeN && sdaOeN)
    else $error("data pin driven while set as input");

endmodule // uss_top

// file: design/uss_cfg.svh
// Register offsets, field positions and reset values of the serial shift unit.
//
// Overview of operation
// R01: Counter wrap fifteen to zero sets overflow.
// R02: Overflow clears on written one, releases hold.
// R03: Overflow interrupt when flag and enables set.
// R04: Start flag: bus start, else counter increment.
// R05: Start clears on written one, releases hold.
// R06: Start interrupt when flag and enables set.
// R07: Start interrupt wakes from every sleep mode.
// R08: Overflow interrupt wakes from idle only.
// R09: Stop flag on bus stop, no interrupt.
// R10: Collision reads shift MSB differing from pin.
// R11: Counter readable and writable in status nibble.
// R12: Counter counts ticks of selected clock source.
// R13: External source plus strobe select uses toggle.
// R14: External pin: both edges increment counter.
// R15: Data write hits shift register, beats shift.
// R16: Shift toward MSB taking data input.
// R17: Inputs feed unit even with outputs disabled.
// R18: Data output pin fed from MSB via latch.
// R19: Latch half-open external, always open internal.
// R20: Data pin driven only when direction is output.
// R21: Pending flag interrupts once enables become set.
// R22: Software presets counter to fifteen for edge interrupt.
// R23: Wire mode: off, three-wire, two-wire, two-wire.
// R24: Mode three also holds clock after overflow.
`ifndef USS_CFG_SVH
`define USS_CFG_SVH

// Register indexes; the byte address is four times the index.
`define USS_IDX_CTRL 8'hb8
`define USS_IDX_STATUS 8'hb9
`define USS_IDX_DATA 8'hba
`define USS_IDX_AUX 8'hbb

// Status register fields.
`define USS_ST_START 7
`define USS_ST_OVF 6
`define USS_ST_STOP 5
`define USS_ST_COLL 4

// Control register strobe fields.
`define USS_CR_STROBE 1
`define USS_CR_TOGGLE 0

// Auxiliary register fields.
`define USS_AUX_CPORT 5

// Reset values.
`define USS_CTRL_RST 8'h00
`define USS_STATUS_RST 8'h00
`define USS_DATA_RST 8'h00
`define USS_AUX_RST 8'h60

// Counter top value and idle sleep code.
`define USS_CNT_MAX 4'hf
`define USS_SLEEP_IDLE 2'h1

`endif

// file: design/uss_pkg.sv
// Types shared by the serial shift unit files.
package uss_pkg;

  // Wire mode encodings.
  typedef enum logic [1:0] {
    USS_WIRE_OFF = 2'h0,
    USS_WIRE_THREE = 2'h1,
    USS_WIRE_TWO = 2'h2,
    USS_WIRE_TWO_HOLD = 2'h3
  } uss_wire_e;

  // Control register layout.
  typedef struct packed {
    logic startIrqEnable;
    logic overflowIrqEnable;
    uss_wire_e wireModeSelect;
    logic [1:0] clockSourceSelect;
    logic clockStrobeSelect;
    logic clockToggleStrobe;
  } uss_ctrl_s;

  // Auxiliary register layout: global enable, sleep, pin directions, ports.
  typedef struct packed {
    logic spare;
    logic dataPort;
    logic clkPort;
    logic clkDirOut;
    logic dataDirOut;
    logic [1:0] sleepMode;
    logic globalIrqEnable;
  } uss_aux_s;

endpackage

// file: design/uss_sync.sv
// Two-stage synchroniser for pin levels.
`timescale 1ns/1ps
module uss_sync #(
  parameter int WIDTH = 2
) (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic reset,
  // Levels from outside and their synchronised copies.
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  // First stage is read only by the second stage.
  logic [WIDTH-1:0] stageOne;

  // Both stages reset to zero.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      stageOne <= '0;
      syncOut <= '0;
    end else begin
      stageOne <= asyncIn;
      syncOut <= stageOne;
    end
  end

endmodule // uss_sync

// file: design/uss_bus_cond.sv
// Start and stop condition detector for the two-wire bus.
`timescale 1ns/1ps
module uss_bus_cond (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic reset,
  // Detector enable and synchronised line levels.
  input wire logic enable,
  input wire logic sdaLevel,
  input wire logic sclLevel,
  // One-cycle condition pulses.
  output logic startSeen,
  output logic stopSeen
);

  // Previous data line level, for edge finding.
  logic sdaPrev;

  // Track the data line each cycle.
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sdaPrev <= 1'b1;
    end else begin
      sdaPrev <= sdaLevel;
    end
  end

  // A data edge while the clock is high marks a condition.
  assign startSeen = enable & sclLevel & sdaPrev & ~sdaLevel;
  assign stopSeen = enable & sclLevel & ~sdaPrev & sdaLevel;

endmodule // uss_bus_cond

// file: sim/uss_peer_model.sv
// Behavioural serial peer that drives the clock and data lines.
`timescale 1ns/1ps
module uss_peer_model (
  // Line levels from the peer; a released line reads high.
  output logic sclLine,
  output logic sdaLine
);
  // The clock starts low, so no stray edge counts before the first frame.
  initial begin
    sclLine = 1'b0;
    sdaLine = 1'b0;
  end

  // Sends a byte MSB first; data moves while the clock is low.
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      sdaLine = b[i];
      #200 sclLine = 1'b1;
      #200 sclLine = 1'b0;
    end
    // The line stops holding the last bit once the frame is over.
    sdaLine = ~b[0];
  endtask

  // Start then stop, both made by data moving under a high clock.
  task automatic start_stop();
    sdaLine = 1'b1;
    #200 sclLine = 1'b1;
    #200 sdaLine = 1'b0;
    #200 sdaLine = 1'b1;
    #200;
  endtask
endmodule // uss_peer_model

// file: sim/uss_top_tb_top.sv
// Self-checking bench for the serial shift unit.
`timescale 1ns/1ps
`include "uss_cfg.svh"
module uss_top_tb_top;
  // Byte addresses are four times the register index.
  localparam logic [11:0] A_CTRL = {2'h0, `USS_IDX_CTRL, 2'h0};
  localparam logic [11:0] A_STAT = {2'h0, `USS_IDX_STATUS, 2'h0};
  localparam logic [11:0] A_DATA = {2'h0, `USS_IDX_DATA, 2'h0};
  localparam logic [11:0] A_AUX = {2'h0, `USS_IDX_AUX, 2'h0};
  logic clk_sys, reset, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic timerMatch, sdaOut, sdaOeN, doOut, doOeN, clkOut, clkOeN;
  logic irqStart, irqOverflow, wakeReq, peerScl, peerSda, errBit;
  int errTotal = 0;
  int testsRun = 0;
  // Open-drain lines: the unit can only pull a line low.
  wire logic dataIn = peerSda & (sdaOeN | sdaOut);
  wire logic clkIn = peerScl & (clkOeN | clkOut);

  uss_top i_uss_top (.clk_sys(clk_sys), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timerMatch(timerMatch), .dataIn(dataIn), .sdaOut(sdaOut),
    .sdaOeN(sdaOeN), .doOut(doOut), .doOeN(doOeN), .clkIn(clkIn),
    .clkOut(clkOut), .clkOeN(clkOeN), .irqStart(irqStart),
    .irqOverflow(irqOverflow), .wakeReq(wakeReq));
  uss_peer_model i_uss_peer_model (.sclLine(peerScl), .sdaLine(peerSda));

  // A 50 ns system clock.
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // Prints the verdict and ends the run; every path comes here.
  task automatic stopTest();
    if (errTotal == 0 && testsRun > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Compares one value and counts the outcome.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string msg);
    testsRun++;
    if (got !== exp) begin
      errTotal++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask

  // One APB transfer, entered just after a rising edge. One edge passes
  // first, so back-to-back calls never set psel twice in one time step.
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    // The access ends at the edge where pready is seen high.
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      errTotal++;
      $display("CHECK FAILED %0t bus timeout", $time);
      stopTest();
    end
    q = prdata;
    errBit = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Waits the fixed settling cycles of flags, requests and pins.
  task automatic settle();
    repeat (4) @(posedge clk_sys);
  endtask

  // Status reset value and an unmapped address.
  task automatic t_reset();
    apb(1'b0, A_STAT, 8'h00);
    chk(q, 32'h0, "status reset");
    apb(1'b0, 12'h2f0, 8'h00);
    chk({31'h0, errBit}, 32'h1, "unmapped error");
    chk(q, 32'h0, "unmapped data");
  endtask

  // Software strobe from a preset of fifteen wraps the counter.
  task automatic t_soft();
    apb(1'b1, A_DATA, 8'h81);
    apb(1'b1, A_STAT, 8'h0f);
    apb(1'b0, A_STAT, 8'h00);
    chk(q & 32'hf, 32'hf, "counter preset");
    apb(1'b1, A_CTRL, 8'h02);
    apb(1'b0, A_STAT, 8'h00);
    chk(q & 32'hef, 32'hc0, "wrap flags");
    apb(1'b0, A_DATA, 8'h00);
    chk(q, 32'h02, "soft shift");
  endtask

  // Requests follow flags, enables and the sleep mode.
  task automatic t_irq();
    apb(1'b1, A_AUX, 8'h63);
    apb(1'b1, A_CTRL, 8'h40);
    settle();
    chk({31'h0, irqOverflow}, 32'h1, "overflow irq");
    chk({31'h0, wakeReq}, 32'h1, "idle wake");
    apb(1'b1, A_AUX, 8'h65);
    settle();
    chk({31'h0, wakeReq}, 32'h0, "deep no wake");
    apb(1'b1, A_CTRL, 8'hc0);
    settle();
    chk({31'h0, irqStart}, 32'h1, "start irq");
    chk({31'h0, wakeReq}, 32'h1, "deep start wake");
    apb(1'b1, A_STAT, 8'h40);
    settle();
    chk({31'h0, irqOverflow}, 32'h0, "overflow clear");
    chk({31'h0, irqStart}, 32'h1, "start kept");
    apb(1'b1, A_STAT, 8'h80);
    settle();
    chk({31'h0, irqStart}, 32'h0, "start clear");
    apb(1'b1, A_AUX, 8'h60);
  endtask

  // Timer ticks count, and a write beats a coincident tick.
  task automatic t_timer();
    apb(1'b1, A_CTRL, 8'h04);
    apb(1'b1, A_STAT, 8'h00);
    repeat (3) begin
      timerMatch <= 1'b1;
      @(posedge clk_sys);
      timerMatch <= 1'b0;
      @(posedge clk_sys);
    end
    apb(1'b0, A_STAT, 8'h00);
    chk(q & 32'hf, 32'h3, "timer count");
    timerMatch <= 1'b1;
    apb(1'b1, A_DATA, 8'h5a);
    timerMatch <= 1'b0;
    apb(1'b0, A_DATA, 8'h00);
    chk(q, 32'h5a, "write beats shift");
  endtask

  // A byte from the pin: sixteen edges wrap the counter once.
  task automatic t_pin();
    apb(1'b1, A_CTRL, 8'h08);
    apb(1'b1, A_STAT, 8'h40);
    i_uss_peer_model.send_byte(8'ha5);
    settle();
    apb(1'b0, A_STAT, 8'h00);
    chk(q & 32'h4f, 32'h40, "edge count");
    apb(1'b0, A_DATA, 8'h00);
    chk(q, 32'ha5, "pin byte");
    apb(1'b1, A_CTRL, 8'h0b);
    apb(1'b0, A_STAT, 8'h00);
    chk(q & 32'hf, 32'h1, "toggle strobe");
  endtask

  // Two-wire start, stop and collision sensing.
  task automatic t_two();
    apb(1'b1, A_STAT, 8'he0);
    apb(1'b1, A_CTRL, 8'h20);
    i_uss_peer_model.start_stop();
    settle();
    apb(1'b0, A_STAT, 8'h00);
    chk(q & 32'ha0, 32'ha0, "start and stop");
    apb(1'b1, A_DATA, 8'h00);
    settle();
    apb(1'b0, A_STAT, 8'h00);
    chk(q & 32'h10, 32'h10, "collision");
    apb(1'b1, A_DATA, 8'h80);
    settle();
    apb(1'b0, A_STAT, 8'h00);
    chk(q & 32'h10, 32'h0, "no collision");
    // Both line drivers enabled: a zero MSB pulls the data line low.
    apb(1'b1, A_AUX, 8'h78);
    apb(1'b1, A_DATA, 8'h00);
    settle();
    chk({29'h0, sdaOut, sdaOeN, clkOeN}, 32'h1, "sda pulled");
    // The toggle strobe drops the clock port bit, so the clock is pulled.
    apb(1'b1, A_CTRL, 8'h21);
    settle();
    chk({30'h0, clkOut, clkOeN}, 32'h0, "scl pulled");
    // Clear the start hold, then wrap in the holding two-wire mode.
    apb(1'b1, A_STAT, 8'h8f);
    apb(1'b1, A_CTRL, 8'h33);
    settle();
    chk({31'h0, clkOeN}, 32'h0, "overflow hold");
    apb(1'b1, A_STAT, 8'h40);
    settle();
    chk({31'h0, clkOeN}, 32'h1, "hold released");
    apb(1'b1, A_AUX, 8'h60);
  endtask

  // Three-wire output follows the MSB and the direction bit.
  task automatic t_out();
    apb(1'b1, A_CTRL, 8'h10);
    apb(1'b1, A_AUX, 8'h68);
    apb(1'b1, A_DATA, 8'h80);
    settle();
    chk({30'h0, doOut, doOeN}, 32'h2, "out high");
    apb(1'b1, A_DATA, 8'h7f);
    settle();
    chk({31'h0, doOut}, 32'h0, "out low");
    apb(1'b1, A_AUX, 8'h60);
    settle();
    chk({31'h0, doOeN}, 32'h1, "out released");
  endtask

  // Reset for two cycles, then the scenarios in turn.
  initial begin
    reset = 1'b1;
    {psel, penable, pwrite, timerMatch} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    t_reset();
    t_soft();
    t_irq();
    t_timer();
    t_pin();
    t_two();
    t_out();
    stopTest();
  end
endmodule // uss_top_tb_top
